//--- psau_core.sv
/*
  Program space access unit: counter sequencing, table operations, visibility window
  and configuration load at reset.
  Assumes a CPU core that holds a request only while ready_o is high, one at a time.
*/
// The strobed register port and the placing of the registers were left to the implementer.
`default_nettype none

module psau_core
  import psau_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [3:0]   reg_addr_i,
  input  wire logic [15:0]  reg_wdata_i,
  input  wire logic         reg_wr_i,
  input  wire logic         reg_rd_i,
  output logic      [15:0]  reg_rdata_o,
  input  wire logic         fetch_req_i,
  input  wire logic         jump_i,
  input  wire logic [22:0]  jump_addr_i,
  output logic      [22:0]  pc_o,
  output logic      [23:0]  instr_o,
  output logic              fetch_done_o,
  input  wire logic         tbl_req_i,
  input  wire logic         tbl_write_i,
  input  wire logic         tbl_high_i,
  input  wire logic         tbl_byte_i,
  input  wire logic [15:0]  tbl_ea_i,
  input  wire logic [15:0]  tbl_wdata_i,
  output logic      [15:0]  tbl_rdata_o,
  output logic              tbl_done_o,
  input  wire logic         dat_req_i,
  input  wire logic [15:0]  dat_ea_i,
  input  wire logic         dat_byte_i,
  input  wire logic         dat_mov_i,
  input  wire logic         rpt_active_i,
  input  wire logic         rpt_edge_i,
  output logic      [15:0]  win_rdata_o,
  output logic              win_done_o,
  output logic              win_hit_o,
  output logic              ready_o
);

  import psau_pkg::*;

  typedef struct packed {
    psau_state_t st;
    psau_op_t    op;
    logic [1:0]  cnt;
    logic [7:0]  tbl_page;
    logic [7:0]  vis_page;
    logic [15:0] core_ctrl;
    logic [22:0] pc;
    logic [23:0] cfg0;
    logic [23:0] cfg1;
    logic        high;
    logic        byte_m;
    logic        sel;
    logic        cfg_hit;
    logic        cfg_ok;
    logic [1:0]  cfg_idx;
    logic        hit;
    logic [15:0] reg_rdata;
    logic [15:0] tbl_rdata;
    logic        tbl_done;
    logic [15:0] win_rdata;
    logic        win_done;
    logic        win_hit;
    logic [23:0] instr;
    logic        fetch_done;
  } psau_regs_t;

  psau_regs_t r;
  psau_regs_t next_r;
  psau_mem_if mif ();

  psau_store u_store (
    .clk_i (clk_i),
    .m     (mif.store)
  );

  //////////////////////////////////////////////////////////////////////////////

  // Picks the low or high half, then a byte of it, zero-extended
  function automatic logic [15:0] fmt(input logic [23:0] w, input logic high,
                                      input logic byte_m, input logic sel);
    logic [15:0] half;
    half = high ? {8'h00, w[23:16]} : w[15:0];
    if (!byte_m)
      fmt = half;
    else if (sel)
      fmt = {8'h00, half[15:8]};
    else
      fmt = {8'h00, half[7:0]};
  endfunction

  // Upper byte of the high half does not exist, so it gets no lane
  function automatic logic [2:0] lanes(input logic high, input logic byte_m,
                                       input logic sel);
    if (high)
      lanes = (byte_m && sel) ? 3'h0 : 3'h4;
    else if (byte_m)
      lanes = sel ? 3'h2 : 3'h1;
    else
      lanes = 3'h3;
  endfunction

  function automatic logic [1:0] win_cost(input logic mov, input logic rpt,
                                          input logic edge_it);
    // Edge iterations of a repeat loop pay the full two cycles, move or not
    if (rpt)
      win_cost = edge_it ? EXTRA_WIN : EXTRA_RPT;
    else if (mov)
      win_cost = EXTRA_MOV;
    else
      win_cost = EXTRA_WIN;
  endfunction

  logic [21:0] tbl_idx;
  logic        win_sel;

  assign tbl_idx = {r.tbl_page[6:0], tbl_ea_i[15:1]};
  assign win_sel = r.core_ctrl[WIN_EN_BIT] && dat_ea_i[WIN_EA_BIT];

  //////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    next_r       = r;
    next_r.tbl_done   = 1'b0;
    next_r.win_done   = 1'b0;
    next_r.fetch_done = 1'b0;
    next_r.reg_rdata  = 16'h0000;
    mif.rd       = 1'b0;
    mif.wr       = 1'b0;
    mif.idx      = 22'h000000;
    mif.wdata    = 24'h000000;
    mif.wlane    = 3'h0;

    unique case (r.st)
      S_CFG_A:
      begin
        mif.rd     = 1'b1;
        mif.idx    = CFG0_IDX;
        next_r.st  = S_CFG_B;
      end
      S_CFG_B:
      begin
        mif.rd      = 1'b1;
        mif.idx     = CFG1_IDX;
        next_r.cfg0 = mif.rdata;
        next_r.st   = S_CFG_C;
      end
      S_CFG_C:
      begin
        next_r.cfg1 = mif.rdata;
        next_r.st   = S_RUN;
      end
      S_RUN:
      begin
        if (jump_i)
        begin
          next_r.pc = {jump_addr_i[22:1], 1'b0};
        end
        else if (tbl_req_i)
        begin
          next_r.op      = OP_TBL;
          next_r.high    = tbl_high_i;
          next_r.byte_m  = tbl_byte_i;
          next_r.sel     = tbl_ea_i[0];
          next_r.cfg_hit = r.tbl_page[CFG_PAGE_BIT];
          next_r.cfg_ok  = (tbl_idx[21:2] == 20'h00000);
          next_r.cfg_idx = tbl_idx[1:0];
          next_r.cnt     = 2'h0;
          next_r.st      = S_WAIT;
          mif.idx        = tbl_idx;
          mif.rd         = !r.tbl_page[CFG_PAGE_BIT];
          // Configuration space ignores table writes
          mif.wr         = tbl_write_i && !r.tbl_page[CFG_PAGE_BIT];
          mif.wlane      = lanes(tbl_high_i, tbl_byte_i, tbl_ea_i[0]);
          if (tbl_high_i)
            mif.wdata = {tbl_wdata_i[7:0], 16'h0000};
          else if (tbl_byte_i)
            mif.wdata = {8'h00, tbl_wdata_i[7:0], tbl_wdata_i[7:0]};
          else
            mif.wdata = {8'h00, tbl_wdata_i};
        end
        else if (dat_req_i)
        begin
          next_r.op     = OP_WIN;
          next_r.hit    = win_sel;
          next_r.high   = 1'b0;
          next_r.byte_m = dat_byte_i;
          next_r.sel    = dat_ea_i[0];
          next_r.cnt    = win_sel ? win_cost(dat_mov_i, rpt_active_i, rpt_edge_i) : 2'h0;
          next_r.st     = S_WAIT;
          mif.rd        = win_sel;
          // Index takes all 8 bits of vis_page, so page 0xff reaches the config words at CFG0_IDX and CFG1_IDX
          mif.idx       = {r.vis_page, dat_ea_i[14:1]};
        end
        else if (fetch_req_i)
        begin
          next_r.op  = OP_FETCH;
          next_r.cnt = 2'h0;
          next_r.st  = S_WAIT;
          mif.rd     = 1'b1;
          mif.idx    = r.pc[22:1];
        end
      end
      S_WAIT:
      begin
        if (r.cnt != 2'h0)
        begin
          next_r.cnt = r.cnt - 2'h1;
        end
        else
        begin
          next_r.st = S_RUN;
          unique case (r.op)
            OP_FETCH:
            begin
              next_r.instr      = mif.rdata;
              next_r.fetch_done = 1'b1;
              next_r.pc         = {r.pc[22:1] + 22'h000001, 1'b0};
            end
            OP_TBL:
            begin
              next_r.tbl_done = 1'b1;
              if (!r.cfg_hit)
                next_r.tbl_rdata = fmt(mif.rdata, r.high, r.byte_m, r.sel);
              else if (!r.cfg_ok)
                next_r.tbl_rdata = 16'h0000;
              else if (r.cfg_idx == 2'h0)
                next_r.tbl_rdata = fmt(r.cfg0, r.high, r.byte_m, r.sel);
              else if (r.cfg_idx == 2'h1)
                next_r.tbl_rdata = fmt(r.cfg1, r.high, r.byte_m, r.sel);
              else if (r.cfg_idx == 2'h2)
                next_r.tbl_rdata = fmt(ID_WORD, r.high, r.byte_m, r.sel);
              else
                next_r.tbl_rdata = 16'h0000;
            end
            default:
            begin
              next_r.win_done  = 1'b1;
              next_r.win_hit   = r.hit;
              next_r.win_rdata = r.hit ? fmt(mif.rdata, 1'b0, r.byte_m, r.sel) : 16'h0000;
            end
          endcase
        end
      end
      default:
      begin
        next_r.st = S_CFG_A;
      end
    endcase

    // Register port answers in every state so the master never waits
    if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        REG_TBL_PAGE:  next_r.tbl_page  = reg_wdata_i[7:0];
        REG_VIS_PAGE:  next_r.vis_page  = reg_wdata_i[7:0];
        REG_CORE_CTRL: next_r.core_ctrl = reg_wdata_i;
        default:       next_r.core_ctrl = next_r.core_ctrl;
      endcase
    end
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        REG_TBL_PAGE:  next_r.reg_rdata = {8'h00, r.tbl_page};
        REG_VIS_PAGE:  next_r.reg_rdata = {8'h00, r.vis_page};
        REG_CORE_CTRL: next_r.reg_rdata = r.core_ctrl;
        REG_PC_LO:     next_r.reg_rdata = r.pc[15:0];
        REG_PC_HI:     next_r.reg_rdata = {9'h000, r.pc[22:16]};
        default:       next_r.reg_rdata = 16'h0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      r           <= '0;
      r.st        <= S_CFG_A;
      r.op        <= OP_FETCH;
      r.tbl_page  <= TBL_PAGE_RST;
      r.vis_page  <= VIS_PAGE_RST;
      r.core_ctrl <= CORE_CTRL_RST;
      r.pc        <= PC_RST;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign reg_rdata_o  = r.reg_rdata;
  assign pc_o         = r.pc;
  assign instr_o      = r.instr;
  assign fetch_done_o = r.fetch_done;
  assign tbl_rdata_o  = r.tbl_rdata;
  assign tbl_done_o   = r.tbl_done;
  assign win_rdata_o  = r.win_rdata;
  assign win_done_o   = r.win_done;
  assign win_hit_o    = r.win_hit;
  assign ready_o      = r.st[3];

  //////////////////////////////////////////////////////////////////////////////

  logic acc_dat;
  assign acc_dat = (r.st == S_RUN) && !jump_i && !tbl_req_i && dat_req_i;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_pc_lsb_zero: assert property (pc_o[0] == 1'b0)
    else $error("program counter bit 0 is set");

  a_pc_step_two: assert property (fetch_done_o |-> pc_o == $past(pc_o) + PC_STEP)
    else $error("fetch did not advance counter by two");

  a_win_full_cost: assert property (
    acc_dat && win_sel && (rpt_active_i ? rpt_edge_i : !dat_mov_i)
      |-> ##1 (!win_done_o) [*3] ##1 (win_done_o && win_hit_o))
    else $error("window read not answered after two extra cycles");

  a_win_mov_cost: assert property (
    acc_dat && win_sel && dat_mov_i && !rpt_active_i
      |-> ##1 (!win_done_o) [*2] ##1 win_done_o)
    else $error("window move not answered after one extra cycle");

  a_win_rpt_free: assert property (
    acc_dat && win_sel && rpt_active_i && !rpt_edge_i |-> ##1 !win_done_o ##1 win_done_o)
    else $error("repeat loop window read carried overhead");

  a_win_gate_off: assert property (
    acc_dat && !r.core_ctrl[WIN_EN_BIT] |-> ##2 (win_done_o && !win_hit_o))
    else $error("window hit while window disabled");

  a_win_low_half: assert property (
    acc_dat && !dat_ea_i[WIN_EA_BIT] |-> ##2 (win_done_o && !win_hit_o && win_rdata_o == 16'h0000))
    else $error("address below threshold went to program space");

  a_phantom_zero: assert property (tbl_done_o && r.high |-> tbl_rdata_o[15:8] == 8'h00)
    else $error("phantom byte did not read zero");

  a_byte_zero_ext: assert property (
    (tbl_done_o || (win_done_o && win_hit_o)) && r.byte_m
      |-> (tbl_done_o ? tbl_rdata_o[15:8] : win_rdata_o[15:8]) == 8'h00)
    else $error("byte read not zero extended");

  a_boot_copy_seq: assert property (
    // Sampled reset keeps the release edge, where the flops still reset, out of it
    rst_n_i && r.st == S_CFG_A |=> r.st == S_CFG_B ##1 r.st == S_CFG_C ##1 ready_o)
    else $error("configuration load sequence broken");

  a_cfg_stable_run: assert property (
    r.st == S_RUN |=> $stable(r.cfg0) && $stable(r.cfg1))
    else $error("configuration registers changed after load");

endmodule

`default_nettype wire

//--- psau_core_test.sv
/*
  Self-checking bench of the program space access unit with a program-word model.
  Assumes the store keeps its contents across a reset.
*/
`default_nettype none
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module psau_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  import psau_pkg::*;
  // {move, repeat, edge} and the window latency each combination must give
  localparam logic [2:0] WCASE [6] = '{3'h0, 3'h4, 3'h2, 3'h6, 3'h3, 3'h7};
  localparam int         WLAT  [6] = '{4, 3, 2, 2, 4, 4};
  logic        clk_i, rst_n_i, reg_wr_i, reg_rd_i, fetch_req_i, jump_i, tbl_req_i;
  logic        tbl_write_i, tbl_high_i, tbl_byte_i, dat_req_i, dat_byte_i, dat_mov_i;
  logic        rpt_active_i, rpt_edge_i, fetch_done_o, tbl_done_o, win_done_o;
  logic        win_hit_o, ready_o;
  logic [3:0]  reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, tbl_ea_i, tbl_wdata_i, tbl_rdata_o;
  logic [15:0] dat_ea_i, win_rdata_o;
  logic [22:0] jump_addr_i, pc_o;
  logic [23:0] instr_o;
  logic [23:0] mem_m [int];
  logic [7:0]  tbl_pg;
  int          err_total, n_compared;
  wire logic   any_done = fetch_done_o | tbl_done_o | win_done_o;
  psau_core psau_core_inst (.clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .fetch_req_i, .jump_i, .jump_addr_i, .pc_o, .instr_o,
    .fetch_done_o, .tbl_req_i, .tbl_write_i, .tbl_high_i, .tbl_byte_i, .tbl_ea_i,
    .tbl_wdata_i, .tbl_rdata_o, .tbl_done_o, .dat_req_i, .dat_ea_i, .dat_byte_i,
    .dat_mov_i, .rpt_active_i, .rpt_edge_i, .win_rdata_o, .win_done_o, .win_hit_o,
    .ready_o);
  psau_cpu_model cpu_inst (.clk_i, .ready_i(ready_o), .done_i(any_done),
    .fetch_o(fetch_req_i), .jump_o(jump_i), .jaddr_o(jump_addr_i), .tbl_o(tbl_req_i),
    .twr_o(tbl_write_i), .thigh_o(tbl_high_i), .tbyte_o(tbl_byte_i), .tea_o(tbl_ea_i),
    .twd_o(tbl_wdata_i), .dat_o(dat_req_i), .dea_o(dat_ea_i), .dbyte_o(dat_byte_i),
    .dmov_o(dat_mov_i), .rpt_o(rpt_active_i), .redge_o(rpt_edge_i));
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic int tix(logic [7:0] p, logic [15:0] ea);
    return int'({p[6:0], ea[15:1]});
  endfunction
  function automatic logic [15:0] sel(logic [23:0] w, logic h, b, a0);
    logic [15:0] v;
    v = h ? {8'h00, w[23:16]} : w[15:0];
    if (b) v = {8'h00, v[{a0, 3'h0} +: 8]};
    return v;
  endfunction
  function automatic logic [15:0] ex(logic h, b, logic [15:0] ea);
    return sel(mem_m[tix(tbl_pg, ea)], h, b, ea[0]);
  endfunction
  task automatic end_of_test();
    if (err_total == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic hang();
    err_total++;
    end_of_test();
  endtask
  task automatic rwr(logic [3:0] a, logic [15:0] d);
    @(posedge clk_i);
    {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rchk(logic [3:0] a, logic [15:0] e);
    @(posedge clk_i);
    {reg_rd_i, reg_addr_i} <= {1'b1, a};
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    `CHK(reg_rdata_o, e)
  endtask
  task automatic setpg(logic [7:0] p);
    rwr(REG_TBL_PAGE, {8'h00, p});
    tbl_pg = p;
  endtask
  task automatic tw(logic h, b, logic [15:0] ea, wd);
    int          i;
    logic [23:0] w;
    cpu_inst.tbl(1'b1, h, b, ea, wd, i);
    i = tix(tbl_pg, ea);
    w = mem_m.exists(i) ? mem_m[i] : 24'h000000;
    if (!h && !b) w[15:0] = wd;
    if (!h && b) w[{ea[0], 3'h0} +: 8] = wd[7:0];
    if (h && !(b && ea[0])) w[23:16] = wd[7:0];
    mem_m[i] = w;
  endtask
  task automatic tr(logic h, b, logic [15:0] ea, e);
    int lat;
    cpu_inst.tbl(1'b0, h, b, ea, 16'($urandom()), lat);
    `CHK(tbl_rdata_o, e)
    `CHK(lat, 2)
  endtask
  task automatic rst_pulse();
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int          lat, k;
    logic [15:0] b, ea;
    logic [7:0]  p;
    logic [22:0] pe;
    logic [23:0] w;
    logic        bt;
    {rst_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
    err_total = 0;
    n_compared = 0;
    tbl_pg = 8'h00;
    void'($urandom(32'he03a9741));
    // Config words start defined so the load at reset copies known values
    for (k = 0; k < 2; k++)
    begin
      mem_m[int'(CFG0_IDX) + k] = 24'($urandom());
      psau_core_inst.u_store.mem[CFG0_IDX + 22'(k)] = mem_m[int'(CFG0_IDX) + k];
    end
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (k = 0; k < 6; k++) rchk(k[3:0], 16'h0000);
    p = 8'($urandom()) & 8'h7f;
    b = 16'($urandom()) & 16'hffe0;
    setpg(p);
    rwr(REG_PC_LO, 16'hffff);
    rwr(4'hf, 16'hffff);
    rchk(REG_TBL_PAGE, {8'h00, p});
    rchk(REG_PC_LO, 16'h0000);
    for (k = 0; k < 8; k++)
    begin
      w = {k[0] ? 8'h3f : 8'hff, 16'($urandom())};
      tw(1'b0, 1'b0, b + 16'(2 * k + k % 2), w[15:0]);
      tw(1'b1, 1'b0, b + 16'(2 * k), {8'($urandom()), w[23:16]});
    end
    tw(1'b0, 1'b1, b + 16'h1, 16'($urandom()));
    tw(1'b1, 1'b1, b + 16'h3, 16'hffff);
    tw(1'b1, 1'b1, b + 16'h4, 16'($urandom()));
    for (k = 0; k < 32; k++)
    begin
      ea = b + 16'($urandom() % 16);
      tr(k[1], k[0], ea, ex(k[1], k[0], ea));
    end
    pe = {p[6:0], b[15:1], 1'b0};
    cpu_inst.jump(pe | 23'h000001);
    `CHK(pc_o, pe)
    for (k = 0; k < 3; k++)
    begin
      cpu_inst.fetch(lat);
      `CHK(instr_o, mem_m[tix(p, b) + k])
      `CHK(pc_o, pe + 23'(2 * k + 2))
    end
    rchk(REG_PC_LO, 16'(pe + 23'h000006));
    rwr(REG_VIS_PAGE, {8'h00, p[6:0], b[15]});
    rwr(REG_CORE_CTRL, 16'h0004);
    for (k = 0; k < 6; k++)
    begin
      ea = {1'b1, b[14:0]} + 16'($urandom() % 16);
      bt = 1'($urandom());
      cpu_inst.dat(ea, bt, WCASE[k][2], WCASE[k][1], WCASE[k][0], lat);
      `CHK(lat, WLAT[k])
      `CHK(win_hit_o, 1'b1)
      `CHK(win_rdata_o, sel(mem_m[tix(p, {b[15], ea[14:0]})], 1'b0, bt, ea[0]))
    end
    cpu_inst.dat({1'b0, b[14:0]}, 1'b0, 1'b0, 1'b0, 1'b0, lat);
    `CHK(win_hit_o, 1'b0)
    `CHK(lat, 2)
    `CHK(win_rdata_o, 16'h0000)
    rwr(REG_CORE_CTRL, 16'h0000);
    cpu_inst.dat({1'b1, b[14:0]}, 1'b0, 1'b0, 1'b0, 1'b0, lat);
    `CHK(win_hit_o, 1'b0)
    setpg(8'h7f);
    for (k = 0; k < 4; k++) tw(k[0], 1'b0, 16'hfffc + 16'(2 * (k / 2)), 16'($urandom()));
    rst_pulse();
    setpg(8'h80);
    for (k = 0; k < 6; k++)
      tr(k[0], 1'b0, 16'(2 * (k / 2)), sel(k < 4 ? mem_m[int'(CFG0_IDX) + k / 2] :
        ID_WORD, k[0], 1'b0, 1'b0));
    w = mem_m[int'(CFG0_IDX)];
    cpu_inst.tbl(1'b1, 1'b0, 1'b0, 16'h0000, ~w[15:0], lat);
    setpg(8'h7f);
    tw(1'b0, 1'b0, 16'hfffc, ~w[15:0]);
    setpg(8'h80);
    tr(1'b0, 1'b0, 16'h0000, w[15:0]);
    rwr(REG_VIS_PAGE, 16'h00ff);
    rwr(REG_CORE_CTRL, 16'h0004);
    cpu_inst.dat(16'hfffc, 1'b0, 1'b1, 1'b0, 1'b0, lat);
    `CHK(win_rdata_o, ~w[15:0])
    end_of_test();
  end
endmodule
`undef CHK
`default_nettype wire

//--- psau_cpu_model.sv
/*
  CPU-side requester model: raises fetch, jump, table and data requests.
  Assumes the unit takes a request at an edge where ready is high.
*/
`default_nettype none
module psau_cpu_model
(
  input  wire logic        clk_i,
  input  wire logic        ready_i,
  input  wire logic        done_i,
  output logic             fetch_o,
  output logic             jump_o,
  output logic      [22:0] jaddr_o,
  output logic             tbl_o,
  output logic             twr_o,
  output logic             thigh_o,
  output logic             tbyte_o,
  output logic      [15:0] tea_o,
  output logic      [15:0] twd_o,
  output logic             dat_o,
  output logic      [15:0] dea_o,
  output logic             dbyte_o,
  output logic             dmov_o,
  output logic             rpt_o,
  output logic             redge_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {fetch_o, jump_o, tbl_o, twr_o, thigh_o, tbyte_o, dat_o} = '0;
    {jaddr_o, tea_o, twd_o, dea_o, dbyte_o, dmov_o, rpt_o, redge_o} = '0;
  end
  task automatic take();
    int n;
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (ready_i !== 1'b1 && n < 99);
    if (ready_i !== 1'b1) psau_core_test.hang();
    @(posedge clk_i);
    // Requests drop and addresses flip so stale values are never mistaken for live ones
    {fetch_o, jump_o, tbl_o, dat_o} <= '0;
    jaddr_o <= ~jaddr_o;
    tea_o   <= ~tea_o;
    dea_o   <= ~dea_o;
  endtask
  task automatic finish(output int lat);
    lat = 0;
    do
    begin
      @(negedge clk_i);
      lat++;
    end
    while (done_i !== 1'b1 && lat < 20);
    if (done_i !== 1'b1) psau_core_test.hang();
  endtask
  task automatic jump(input logic [22:0] a);
    @(posedge clk_i);
    jump_o  <= 1'b1;
    jaddr_o <= a;
    take();
    @(negedge clk_i);
  endtask
  task automatic fetch(output int lat);
    @(posedge clk_i);
    fetch_o <= 1'b1;
    take();
    finish(lat);
  endtask
  task automatic tbl(input logic w, h, b, input logic [15:0] ea, wd, output int lat);
    @(posedge clk_i);
    {tbl_o, twr_o, thigh_o, tbyte_o} <= {1'b1, w, h, b};
    tea_o <= ea;
    twd_o <= wd;
    take();
    finish(lat);
  endtask
  task automatic dat(input logic [15:0] ea, input logic b, m, r, e, output int lat);
    @(posedge clk_i);
    {dat_o, dbyte_o, dmov_o, rpt_o, redge_o} <= {1'b1, b, m, r, e};
    dea_o <= ea;
    take();
    finish(lat);
  endtask
endmodule
`default_nettype wire

//--- psau_mem_if.sv
/*
  Port between the access controller and the program store.
  Assumes the store answers a read with registered data one cycle later.
*/
`default_nettype none

interface psau_mem_if;
  logic        rd;
  logic        wr;
  logic [21:0] idx;
  logic [23:0] wdata;
  logic [2:0]  wlane;
  logic [23:0] rdata;

  modport ctrl (output rd, output wr, output idx, output wdata, output wlane, input rdata);
  modport store (input rd, input wr, input idx, input wdata, input wlane, output rdata);
endinterface

`default_nettype wire

//--- psau_pkg.sv
/*
  Shared constants, register offsets and types of the program space access unit.
  Assumes one system clock and a CPU core that issues fetch, table and data requests.
*/
`default_nettype none

package psau_pkg;

  localparam int          PC_W          = 23;
  localparam int          WORD_W        = 24;
  localparam int          IDX_W         = 22;
  localparam int          MEM_WORDS     = 4194304;
  localparam int          REG_A_W       = 4;

  localparam logic [21:0] CFG0_IDX      = 22'h3ffffe;
  localparam logic [21:0] CFG1_IDX      = 22'h3fffff;
  // Arbitrary identification value
  localparam logic [23:0] ID_WORD       = 24'h00a5c3;

  localparam logic [3:0]  REG_TBL_PAGE  = 4'h0;
  localparam logic [3:0]  REG_VIS_PAGE  = 4'h1;
  localparam logic [3:0]  REG_CORE_CTRL = 4'h2;
  localparam logic [3:0]  REG_PC_LO     = 4'h3;
  localparam logic [3:0]  REG_PC_HI     = 4'h4;

  localparam int          WIN_EN_BIT    = 2;
  localparam int          WIN_EA_BIT    = 15;
  localparam int          CFG_PAGE_BIT  = 7;

  localparam logic [7:0]  TBL_PAGE_RST  = 8'h00;
  localparam logic [7:0]  VIS_PAGE_RST  = 8'h00;
  localparam logic [15:0] CORE_CTRL_RST = 16'h0000;
  localparam logic [22:0] PC_RST        = 23'h000000;
  localparam logic [22:0] PC_STEP       = 23'h000002;

  localparam logic [1:0]  EXTRA_WIN     = 2'h2;
  localparam logic [1:0]  EXTRA_MOV     = 2'h1;
  localparam logic [1:0]  EXTRA_RPT     = 2'h0;

  typedef enum logic [4:0] {
    S_CFG_A = 5'h01,
    S_CFG_B = 5'h02,
    S_CFG_C = 5'h04,
    S_RUN   = 5'h08,
    S_WAIT  = 5'h10
  } psau_state_t;

  typedef enum logic [1:0] {
    OP_FETCH = 2'h0,
    OP_TBL   = 2'h1,
    OP_WIN   = 2'h2
  } psau_op_t;

endpackage

`default_nettype wire

//--- psau_store.sv
/*
  Program store: 4M words of 24 bits, byte-lane writes, registered read.
  A table write reads and writes the same word in one cycle; the read returns the old word.
*/
`default_nettype none

module psau_store
  import psau_pkg::*;
(
  input  wire logic clk_i,
  psau_mem_if.store m
);

  logic [23:0] mem [MEM_WORDS];
  logic [23:0] rdata;

  // Data storage needs no reset; the controller owns all control state
  always_ff @(posedge clk_i)
  begin
    if (m.rd)
    begin
      rdata <= mem[m.idx];
    end
    for (int l = 0; l < 3; l++)
    begin
      if (m.wr && m.wlane[l])
      begin
        mem[m.idx][l*8 +: 8] <= m.wdata[l*8 +: 8];
      end
    end
  end

  assign m.rdata = rdata;

endmodule

`default_nettype wire
